/* File: rtl/lsf_pkg.sv */
// Purpose: Shared constants for the light sample FIFO status block
// Assumes: 8-bit register port, one clock domain
// Notes:   Counts are in sample sets, never bytes

package lsf_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] LSF_ADDR_LEVEL = 8'hf0;
	localparam logic [7:0] LSF_ADDR_CTRL  = 8'hf1;

	// Control register field positions
	localparam int LSF_BIT_RSVD  = 7;
	localparam int LSF_BIT_LSB   = 6;
	localparam int LSF_THR_HI    = 5;
	localparam int LSF_THR_LO    = 3;
	localparam int LSF_BIT_FLUSH = 2;
	localparam int LSF_BIT_EMPTY = 1;
	localparam int LSF_BIT_OVF   = 0;

	// Reset values
	localparam logic [7:0] LSF_LEVEL_RST = 8'h00;
	localparam logic [2:0] LSF_THR_RST   = 3'h0;

	// ****************************************************************
	// Counts
	// ****************************************************************
	localparam int         LSF_CNT_W      = 10;
	localparam logic [9:0] LSF_SAT_DUAL   = 10'd256;
	localparam logic [9:0] LSF_SAT_DUAL_W = 10'd512;
	localparam logic [9:0] LSF_SAT_CRGB   = 10'd128;
	localparam logic [9:0] LSF_SAT_CRGB_W = 10'd256;
	localparam logic [9:0] LSF_THR_STEP   = 10'd16;
	localparam logic [9:0] LSF_FIELD_MAX  = 10'd255;
	localparam logic [9:0] LSF_FIELD_MAXW = 10'd511;
	localparam logic [1:0] LSF_SEL_DUAL   = 2'h0;
	localparam logic [1:0] LSF_SEL_CRGB   = 2'h3;

endpackage

/* File: rtl/lsf_set_fifo.sv */
// Purpose: Small valid/ready FIFO for incoming sample sets
// Assumes: Single clock, asynchronous active-high reset
// Notes:   in_ready is registered so it never depends on out_ready

`timescale 1ns/10ps

module lsf_set_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 cnt;
		logic [AW-1:0]               rp;
		logic [AW-1:0]               wp;
		logic                        rdy;
	} lsf_fifo_s;

	lsf_fifo_s q_ff;
	lsf_fifo_s nxt_q;
	logic      push;
	logic      pop;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		nxt_q = q_ff;
		push  = in_valid && q_ff.rdy;
		pop   = out_ready && (q_ff.cnt != '0);
		if (push)
		begin
			nxt_q.mem[q_ff.wp] = in_data;
			nxt_q.wp           = q_ff.wp + 1'b1;
		end
		if (pop)
			nxt_q.rp = q_ff.rp + 1'b1;
		nxt_q.cnt = q_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		// Registered ready from the next count: all DEPTH slots usable, no comb path back
		nxt_q.rdy = (nxt_q.cnt < (AW+1)'(DEPTH));
	end

	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			q_ff <= '{default: '0};
		else
			q_ff <= nxt_q;
	end

	assign in_ready  = q_ff.rdy;
	assign out_valid = (q_ff.cnt != '0);
	assign out_data  = q_ff.mem[q_ff.rp];

endmodule

/* File: rtl/lsf_fill_status.sv */
// Purpose: Fill level, threshold flag and control/status registers of the sample FIFO
// Assumes: Register port is a simple strobe interface behind the serial bus
// Notes:   Sample storage lives outside; this block counts sets and gates writes
//
// Functional notes
// - Fill level counts complete sample sets of all active channels, not bytes.
// - Channel select 0: one count unit equals one two-channel set.
// - Channel select 3: one count unit equals one clear/red/green/blue set.
// - Wide off: level is 8-bit field; wide on: field above the extra bit.
// - Saturate at 256/512 for select 0, 128/256 for select 3.
// - Count at or above threshold sets flag; interrupt only when enabled.
// - Threshold code 0 means none; else sixteen times code, doubled when wide.
// - Flush zeroes the set count and stalls the drain, keeps overflow; issue only when sensing off.
// - Empty flag resets to one; reads from empty FIFO return zero.
// - Overflow sets when full, blocks writes; a FIFO data read clears it.

`timescale 1ns/10ps

module lsf_fill_status
	import lsf_pkg::*;
#(
	parameter int DW    = 32,
	parameter int DEPTH = 4
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [1:0]    photodiode_channel_select,
	input  wire logic          wide_sample_setting,
	input  wire logic          threshold_irq_enable,
	input  wire logic          set_valid,
	output logic               set_ready,
	input  wire logic [DW-1:0] set_data,
	input  wire logic          store_ready,
	output logic               store_valid,
	output logic [DW-1:0]      store_data,
	input  wire logic          set_read,
	output logic               read_zero,
	input  wire logic [7:0]    reg_addr,
	input  wire logic          reg_wr,
	input  wire logic [7:0]    reg_wdata,
	input  wire logic          reg_rd,
	output logic [7:0]         reg_rdata,
	output logic               threshold_reached_flag,
	output logic               threshold_irq
);
	import lsf_pkg::*;

	typedef struct packed {
		logic [LSF_CNT_W-1:0] cnt;
		logic                 ovf;
		logic [2:0]           thr_code;
		logic                 rsvd;
		logic                 flush;
		logic [7:0]           rdata;
		logic                 flag;
		logic                 irq;
		logic                 st_valid;
		logic [DW-1:0]        st_data;
		logic                 rd_zero;
	} lsf_state_s;

	lsf_state_s           q_ff;
	lsf_state_s           nxt_q;
	logic                 fifo_valid;
	logic                 fifo_pop;
	logic [DW-1:0]        fifo_data;
	logic [LSF_CNT_W-1:0] sat;
	logic [LSF_CNT_W-1:0] thr;
	logic                 full;
	logic                 inc;
	logic                 dec;
	logic [8:0]           lvl;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************

	// Saturation point in sets for the channel and width setting
	function automatic logic [LSF_CNT_W-1:0] lsf_sat(input logic [1:0] sel, input logic wide);
		if (sel == LSF_SEL_CRGB)
			return wide ? LSF_SAT_CRGB_W : LSF_SAT_CRGB;
		return wide ? LSF_SAT_DUAL_W : LSF_SAT_DUAL;
	endfunction

	// Threshold in sets; zero code never matches since the flag is gated
	function automatic logic [LSF_CNT_W-1:0] lsf_thr(input logic [2:0] code, input logic wide);
		logic [LSF_CNT_W-1:0] t;
		t = LSF_THR_STEP * {7'h00, code};
		return wide ? {t[LSF_CNT_W-2:0], 1'b0} : t;
	endfunction

	// Level as {field, low bit}; clipped since the top saturation value needs one more bit
	function automatic logic [8:0] lsf_level(input logic [LSF_CNT_W-1:0] c, input logic wide);
		logic [LSF_CNT_W-1:0] v;
		v = c;
		if (wide)
		begin
			if (c > LSF_FIELD_MAXW)
				v = LSF_FIELD_MAXW;
			return {v[8:1], v[0]};
		end
		if (c > LSF_FIELD_MAX)
			v = LSF_FIELD_MAX;
		return {v[7:0], 1'b0};
	endfunction

	// ****************************************************************
	// Incoming set buffer
	// ****************************************************************
	lsf_set_fifo #(
		.WIDTH (DW),
		.DEPTH (DEPTH)
	) u_set_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (set_valid),
		.in_ready  (set_ready),
		.in_data   (set_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// Drain stalls during flush or when storage is busy, so the buffer fills honestly
	assign fifo_pop = fifo_valid && store_ready && !q_ff.flush;

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		nxt_q          = q_ff;
		sat            = lsf_sat(photodiode_channel_select, wide_sample_setting);
		thr            = lsf_thr(q_ff.thr_code, wide_sample_setting);
		full           = (q_ff.cnt >= sat);
		inc            = fifo_pop && !full;
		dec            = set_read && (q_ff.cnt != '0);
		lvl            = lsf_level(q_ff.cnt, wide_sample_setting);
		nxt_q.st_valid = inc;
		nxt_q.st_data  = fifo_data;
		nxt_q.rd_zero  = set_read && (q_ff.cnt == '0);

		// Count whole sets; flush wins over both directions
		if (q_ff.flush)
			nxt_q.cnt = '0;
		else
			nxt_q.cnt = q_ff.cnt + {{(LSF_CNT_W-1){1'b0}}, inc} - {{(LSF_CNT_W-1){1'b0}}, dec};

		// Overflow: a dropped set beats a same-cycle read clear; flush leaves it alone
		if (fifo_pop && full)
			nxt_q.ovf = 1'b1;
		else if (set_read)
			nxt_q.ovf = 1'b0;

		// Control register write
		if (reg_wr && (reg_addr == LSF_ADDR_CTRL))
		begin
			nxt_q.rsvd     = reg_wdata[LSF_BIT_RSVD];
			nxt_q.thr_code = reg_wdata[LSF_THR_HI:LSF_THR_LO];
			nxt_q.flush    = reg_wdata[LSF_BIT_FLUSH];
		end

		// Register read, unmapped reads as zero
		nxt_q.rdata = q_ff.rdata;
		if (reg_rd)
		begin
			unique case (reg_addr)
				LSF_ADDR_LEVEL: nxt_q.rdata = lvl[8:1];
				LSF_ADDR_CTRL:  nxt_q.rdata = {q_ff.rsvd, lvl[0], q_ff.thr_code, q_ff.flush,
					(q_ff.cnt == '0), q_ff.ovf};
				default:        nxt_q.rdata = 8'h00;
			endcase
		end

		// Level-type threshold flag, interrupt gated by enable
		nxt_q.flag = (q_ff.thr_code != 3'h0) && (q_ff.cnt >= thr);
		nxt_q.irq  = nxt_q.flag && threshold_irq_enable;
	end

	// State register
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			q_ff          <= '{default: '0};
			q_ff.thr_code <= LSF_THR_RST;
			q_ff.rdata    <= LSF_LEVEL_RST;
		end
		else
			q_ff <= nxt_q;
	end

	assign store_valid            = q_ff.st_valid;
	assign store_data             = q_ff.st_data;
	assign read_zero              = q_ff.rd_zero;
	assign reg_rdata              = q_ff.rdata;
	assign threshold_reached_flag = q_ff.flag;
	assign threshold_irq          = q_ff.irq;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_flush_written;
		reg_wr && (reg_addr == LSF_ADDR_CTRL) && reg_wdata[LSF_BIT_FLUSH];
	endsequence

	property p_flush_zero;
		s_flush_written ##1 1'b1 |=> (q_ff.cnt == '0);
	endproperty
	a_flush_zero: assert property (p_flush_zero) else $error("Count not zero after flush");

	property p_no_write_full;
		(q_ff.cnt >= lsf_sat(photodiode_channel_select, wide_sample_setting)) |=> !store_valid;
	endproperty
	a_no_write_full: assert property (p_no_write_full) else $error("Set stored while full");

	property p_ovf_set;
		(fifo_pop && (q_ff.cnt >= lsf_sat(photodiode_channel_select, wide_sample_setting))) |=> q_ff.ovf;
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("Overflow not set on dropped set");

	property p_ovf_clear;
		(set_read && !fifo_pop) |=> !q_ff.ovf;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("Overflow not cleared by read");

	property p_flag;
		1'b1 |=> (threshold_reached_flag == (($past(q_ff.thr_code) != 3'h0)
			&& ($past(q_ff.cnt) >= lsf_thr($past(q_ff.thr_code), $past(wide_sample_setting)))));
	endproperty
	a_flag: assert property (p_flag) else $error("Threshold flag wrong");

	property p_irq_gate;
		threshold_irq |-> threshold_reached_flag;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("Interrupt without flag");

	property p_empty_zero;
		(set_read && (q_ff.cnt == '0)) |=> read_zero && (q_ff.cnt == '0 || $past(fifo_pop));
	endproperty
	a_empty_zero: assert property (p_empty_zero) else $error("Empty read not flagged");

	property p_count_step;
		!q_ff.flush |=> (q_ff.cnt == $past(q_ff.cnt) + {9'h000, store_valid}
			- {9'h000, $past(set_read) && ($past(q_ff.cnt) != '0)});
	endproperty
	a_count_step: assert property (p_count_step) else $error("Count step wrong");

	property p_sat_bound;
		q_ff.cnt <= LSF_SAT_DUAL_W;
	endproperty
	a_sat_bound: assert property (p_sat_bound) else $error("Count beyond largest saturation");

	// Register reads: the answer lands one edge after the strobe edge
	sequence s_level_read;
		reg_rd && (reg_addr == LSF_ADDR_LEVEL);
	endsequence

	sequence s_ctrl_read;
		reg_rd && (reg_addr == LSF_ADDR_CTRL);
	endsequence

	// Narrow level reads back the low count byte while it still fits
	property p_level_narrow;
		s_level_read ##0 (!wide_sample_setting && (q_ff.cnt <= LSF_FIELD_MAX))
			|=> (reg_rdata == $past(q_ff.cnt[7:0]));
	endproperty
	a_level_narrow: assert property (p_level_narrow) else $error("Narrow level read wrong");

	// Wide level drops the low bit into the control register
	property p_level_wide;
		s_level_read ##0 (wide_sample_setting && (q_ff.cnt <= LSF_FIELD_MAXW))
			|=> (reg_rdata == $past(q_ff.cnt[8:1]));
	endproperty
	a_level_wide: assert property (p_level_wide) else $error("Wide level read wrong");

	// Status bits of the control register mirror empty and overflow
	property p_ctrl_status;
		s_ctrl_read |=> (reg_rdata[LSF_BIT_EMPTY] == ($past(q_ff.cnt) == '0))
			&& (reg_rdata[LSF_BIT_OVF] == $past(q_ff.ovf));
	endproperty
	a_ctrl_status: assert property (p_ctrl_status) else $error("Control status bits wrong");

	// Read data must stand until the host asks again
	property p_rdata_hold;
		!reg_rd |=> $stable(reg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("Read data changed without a read");

	// Interrupt is the flag gated by the enable seen one edge earlier
	property p_irq_follow;
		1'b1 |=> (threshold_irq == (threshold_reached_flag && $past(threshold_irq_enable)));
	endproperty
	a_irq_follow: assert property (p_irq_follow) else $error("Interrupt does not follow flag");

	// While flushing nothing is stored and the count stays at zero
	property p_flush_hold;
		q_ff.flush |=> (!store_valid && (q_ff.cnt == '0));
	endproperty
	a_flush_hold: assert property (p_flush_hold) else $error("Set stored during flush");

	// Flush leaves overflow alone; only a host read may clear it
	property p_flush_ovf;
		(q_ff.flush && !set_read) |=> (q_ff.ovf == $past(q_ff.ovf));
	endproperty
	a_flush_ovf: assert property (p_flush_ovf) else $error("Flush changed overflow");

endmodule

/* File: testbench/lsf_store_sink.sv */
// Purpose: Sample storage sink that stands behind the fill status block
// Assumes: One clock; ready changes only on the falling edge
// Notes:   Stalls one cycle in four so the set buffer backs up

`timescale 1ns/10ps

module lsf_store_sink (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        stall,
	input  wire logic        store_valid,
	input  wire logic [31:0] store_data,
	output logic             store_ready,
	output int               stored,
	output logic [31:0]      last_data
);
	logic [1:0] ph_ff;

	// ****************************************************************
	// Ready pattern and stored set count
	// ****************************************************************
	// Phase counter moves off the sampling edge to avoid races
	always @(negedge clk or posedge rst)
	begin
		if (rst)
			ph_ff <= 2'h0;
		else
			ph_ff <= ph_ff + 2'h1;
	end

	// A forced stall lets the bench fill the buffer until it refuses
	assign store_ready = !stall && (ph_ff != 2'h3);

	// Count every stored set and keep the last word for the bench
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			stored    <= 0;
			last_data <= 32'h0000_0000;
		end
		else if (store_valid === 1'b1)
		begin
			stored    <= stored + 1;
			last_data <= store_data;
		end
	end
endmodule

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the sample FIFO fill status block
// Assumes: Inputs driven at the falling edge of a 25 MHz clock
// Notes:   Each table row starts from a flushed buffer

`timescale 1ns/10ps

module tb_top;
	import lsf_pkg::*;

	typedef struct {logic [1:0] sel; logic w; logic [2:0] thr; int n;
		logic [7:0] f0; logic [7:0] f1; logic fl; int st;} lsf_row_s;

	logic        clk = 0, rst = 1, wide = 0, irq_en = 0, set_valid = 0, set_read = 0, reg_wr = 0, reg_rd = 0, stall = 0;
	logic [1:0]  sel = 2'h0;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [31:0] set_data = 32'h0000_00a5;
	logic [31:0] store_data, last_data;
	logic        set_ready, store_valid, store_ready, read_zero, flag, irq;
	int          fail_count = 0, checks = 0, cyc = 0, stored, b;
	// Mode, threshold code, sets pushed, level, control, flag, sets stored
	lsf_row_s    rows [9] = '{'{2'h0, 1'b0, 3'h1, 16, 8'h10, 8'h08, 1'b1, 16},
		'{2'h0, 1'b0, 3'h1, 15, 8'h0f, 8'h08, 1'b0, 15}, '{2'h0, 1'b1, 3'h1, 31, 8'h0f, 8'h48, 1'b0, 31},
		'{2'h0, 1'b1, 3'h1, 32, 8'h10, 8'h08, 1'b1, 32}, '{2'h3, 1'b0, 3'h7, 112, 8'h70, 8'h38, 1'b1, 112},
		'{2'h3, 1'b0, 3'h0, 20, 8'h14, 8'h00, 1'b0, 20}, '{2'h0, 1'b0, 3'h2, 0, 8'h00, 8'h12, 1'b0, 0},
		'{2'h2, 1'b0, 3'h7, 130, 8'h82, 8'h38, 1'b1, 130}, '{2'h3, 1'b0, 3'h7, 130, 8'h80, 8'h39, 1'b1, 128}};

	lsf_fill_status uut (.clk(clk), .rst(rst), .photodiode_channel_select(sel), .wide_sample_setting(wide),
		.threshold_irq_enable(irq_en), .set_valid(set_valid), .set_ready(set_ready), .set_data(set_data),
		.store_ready(store_ready), .store_valid(store_valid), .store_data(store_data), .set_read(set_read),
		.read_zero(read_zero), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .threshold_reached_flag(flag), .threshold_irq(irq));
	lsf_store_sink sink (.clk(clk), .rst(rst), .stall(stall), .store_valid(store_valid),
		.store_data(store_data), .store_ready(store_ready), .stored(stored), .last_data(last_data));

	// ****************************************************************
	// Clock, timeout and shared tasks
	// ****************************************************************
	always #20 clk = ~clk;

	// Whole run needs about a thousand cycles; a hang is cut well above that
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			results();
		end
	end

	task chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask

	task chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask

	task chk1(input string nm, input logic exp, input logic got);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %s exp %b got %b", nm, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clk);
		reg_wr = 0;
		@(negedge clk);
	endtask

	task rdchk(input logic [7:0] a, input logic [7:0] exp);
		reg_addr = a;
		reg_rd = 1;
		@(negedge clk);
		reg_rd = 0;
		@(negedge clk);
		chk8("reg_rdata", exp, reg_rdata);
	endtask

	// Flush pulse keeps set input idle, as sensing must be off then
	task setup(input logic [1:0] s, input logic w, input logic [2:0] t);
		sel = s;
		wide = w;
		wr(LSF_ADDR_CTRL, {2'h0, t, 3'h4});
		wr(LSF_ADDR_CTRL, {2'h0, t, 3'h0});
	endtask

	// Valid is held until ready was seen before the taking edge; each taken set gets a new word
	task push(input int n);
		int   k;
		logic took;
		k = 0;
		set_valid = (n > 0);
		while (k < n)
		begin
			took = (set_ready === 1'b1);
			@(negedge clk);
			if (took)
			begin
				k++;
				set_data = set_data + 32'h0000_0001;
			end
		end
		set_valid = 0;
	endtask

	task drain(input int exp);
		int k;
		k = 0;
		while (stored != exp && k < 2000)
		begin
			@(negedge clk);
			k++;
		end
		repeat (4) @(negedge clk);
	endtask

	task host_read(input logic exp_zero);
		set_read = 1;
		@(negedge clk);
		set_read = 0;
		chk1("read_zero", exp_zero, read_zero);
		@(negedge clk);
	endtask

	task results;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		repeat (20) @(negedge clk);
		rst = 0;
		@(negedge clk);
		rdchk(LSF_ADDR_LEVEL, LSF_LEVEL_RST);
		rdchk(LSF_ADDR_CTRL, 8'h02);
		rdchk(8'h33, 8'h00);
		foreach (rows[i])
		begin
			irq_en = (i % 2 == 1);
			setup(rows[i].sel, rows[i].w, rows[i].thr);
			b = stored;
			push(rows[i].n);
			drain(b + rows[i].st);
			rdchk(LSF_ADDR_LEVEL, rows[i].f0);
			rdchk(LSF_ADDR_CTRL, rows[i].f1);
			chk1("flag", rows[i].fl, flag);
			chk1("irq", rows[i].fl & irq_en, irq);
		end
		// Buffer is saturated with overflow set; a read steps it back
		host_read(1'b0);
		rdchk(LSF_ADDR_LEVEL, 8'h7f);
		rdchk(LSF_ADDR_CTRL, 8'h38);
		b = stored;
		push(2);
		drain(b + 1);
		rdchk(LSF_ADDR_CTRL, 8'h39);
		wr(LSF_ADDR_CTRL, 8'h3c);
		rdchk(LSF_ADDR_CTRL, 8'h3f);
		wr(LSF_ADDR_CTRL, 8'h38);
		rdchk(LSF_ADDR_LEVEL, 8'h00);
		host_read(1'b1);
		rdchk(LSF_ADDR_CTRL, 8'h3a);
		// Far side stalls until the set buffer refuses, then drains
		stall = 1;
		push(4);
		repeat (2) @(negedge clk);
		chk1("set_ready", 1'b0, set_ready);
		b = stored;
		stall = 0;
		drain(b + 4);
		chk32("store_data", set_data - 32'h0000_0001, last_data);
		wr(LSF_ADDR_LEVEL, 8'hff);
		rdchk(LSF_ADDR_LEVEL, 8'h04);
		results();
	end
endmodule
